// ==== design/lcsi_top.sv ====
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - lamp one red while outputs off, green on, green 1 Hz when weak
// - lamp one red 1 Hz on external fault, red 10 Hz on internal
// - lamp two dark: interlock off, released, or locked with field broken
// - lamp two steady yellow when interlock locked, field clear, upstream ok
// - lamp two blinks yellow while upstream safety circuit is open
// - upstream changeover gives a burst of one or two yellow blinks
// - lamp three dark with no special function active
// - lamp three steady blue once blanking parameters are taught
// - lamp three blue 1 Hz while muting is active
// - lamp three short flashes: teaching, muting restart, muting override
// - lamp three blue 10 Hz when teaching fails
// - wiring drives channel inputs opposite; high-low picks channel one
module lcsi_top
  import lcsi_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned FLASH_ON = FLASH_ON_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic safety_output_one,
  input wire logic safety_output_two,
  input wire logic channel_select_a,
  input wire logic channel_select_b,
  output logic optical_channel_one,
  output logic optical_channel_two,
  output logic lamp1_red,
  output logic lamp1_green,
  output logic lamp2_yellow,
  output logic lamp3_blue
);
  lcsi_blink_if bl ();

  logic [3:0] pins_sync;
  logic outputs_on;
  logic [1:0] ctrl;
  logic [ST_W-1:0] state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_state;
  logic wr_cmd;
  logic burst_req;
  logic burst_two;
  lcsi_burst_t burst;
  lcsi_burst_t next_burst;
  logic [1:0] burst_left;
  logic burst_lit;
  logic burst_act;
  logic next_red;
  logic next_green;
  logic next_yellow;
  logic next_blue;

  // register decode for the read path; writes compare wr_addr directly
  function automatic logic [31:0] read_reg(input logic [7:0] ofs,
      input logic [1:0] c, input logic [ST_W-1:0] s, input logic [7:0] lp);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (ofs)
      CTRL_OFS: r = {30'h0, 1'b0, c[CTRL_EN_BIT]};
      STATE_OFS: r = {{(32 - ST_W){1'b0}}, s};
      LAMP_OFS: r = {24'h0, lp};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // pin synchroniser and channel decode
  lcsi_pin_in u_pins (
    .clock(clock),
    .rst_n(rst_n),
    .pins({channel_select_b, channel_select_a,
           safety_output_two, safety_output_one}),
    .pins_sync(pins_sync),
    .optical_channel_one(optical_channel_one),
    .optical_channel_two(optical_channel_two)
  );

  // blink rate generator
  lcsi_blink_gen #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF),
    .FLASH_ON(FLASH_ON)
  ) u_blink (
    .clock(clock),
    .rst_n(rst_n),
    .bl(bl)
  );

  // both safety outputs must be on to count as on
  assign outputs_on = pins_sync[0] & pins_sync[1];

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];

  // address phase of a write is held for the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // write strobes, effective in the data phase
  assign wr_ctrl = wr_pend && (wr_addr == CTRL_OFS);
  assign wr_state = wr_pend && (wr_addr == STATE_OFS);
  assign wr_cmd = wr_pend && (wr_addr == CMD_OFS);

  // read data registered at the address phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= read_reg(haddr[7:0], ctrl, state,
        {outputs_on, burst_act, optical_channel_two, optical_channel_one,
         lamp3_blue, lamp2_yellow, lamp1_green, lamp1_red});
    end
  end

  // control: lamp enable, and a one-cycle blink restart
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {hwdata[CTRL_RESTART_BIT], hwdata[CTRL_EN_BIT]};
    end else begin
      ctrl[CTRL_RESTART_BIT] <= 1'b0;
    end
  end
  assign bl.restart = ctrl[CTRL_RESTART_BIT];

  // device state reported by the supervising logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= STATE_RST;
    end else if (wr_state) begin
      state <= hwdata[ST_W-1:0];
    end
  end

  // changeover command pulse
  assign burst_req = wr_cmd && hwdata[CMD_BURST_BIT];
  assign burst_two = hwdata[CMD_TWO_BIT];

  // changeover burst sequencer, aligned to the slow blink edges
  always_comb begin
    next_burst = burst;
    case (burst)
      LCSI_B_IDLE: next_burst = LCSI_B_IDLE;
      LCSI_B_WAIT: if (bl.slow_tick) begin
        next_burst = LCSI_B_ON;
      end
      LCSI_B_ON: if (bl.slow_tick) begin
        next_burst = LCSI_B_OFF;
      end
      LCSI_B_OFF: if (bl.slow_tick) begin
        next_burst = (burst_left == 2'h1) ? LCSI_B_IDLE : LCSI_B_ON;
      end
      default: next_burst = LCSI_B_IDLE;
    endcase
    if (burst_req) begin
      next_burst = LCSI_B_WAIT;
    end
  end

  // burst state and remaining blink count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      burst <= LCSI_B_IDLE;
      burst_left <= 2'h0;
    end else begin
      burst <= next_burst;
      if (burst_req) begin
        burst_left <= burst_two ? 2'h2 : 2'h1;
      end else if (burst == LCSI_B_OFF && bl.slow_tick) begin
        burst_left <= burst_left - 2'h1;
      end
    end
  end
  assign burst_act = (burst != LCSI_B_IDLE);
  assign burst_lit = (burst == LCSI_B_ON);

  // lamp one: faults first, then output state
  always_comb begin
    next_red = 1'b0;
    next_green = 1'b0;
    if (!ctrl[CTRL_EN_BIT]) begin
      next_red = 1'b0;
    end else if (state[ST_INT_FAULT]) begin
      next_red = bl.fast;
    end else if (state[ST_EXT_FAULT]) begin
      next_red = bl.slow;
    end else if (outputs_on && state[ST_WEAK]) begin
      next_green = bl.slow;
    end else if (outputs_on) begin
      next_green = 1'b1;
    end else begin
      next_red = 1'b1;
    end
  end

  // lamp two: changeover burst, open upstream, releasable interlock
  always_comb begin
    next_yellow = 1'b0;
    if (!ctrl[CTRL_EN_BIT]) begin
      next_yellow = 1'b0;
    end else if (burst_act) begin
      next_yellow = burst_lit;
    end else if (state[ST_UP_OPEN]) begin
      next_yellow = bl.slow;
    end else if (state[ST_RI_ENABLED] && !state[ST_RI_RELEASED] &&
                 state[ST_FIELD_CLEAR] && state[ST_UP_ENABLE]) begin
      next_yellow = 1'b1;
    end else begin
      next_yellow = 1'b0;
    end
  end

  // lamp three: teach error, short flash, muting, taught
  always_comb begin
    next_blue = 1'b0;
    if (!ctrl[CTRL_EN_BIT]) begin
      next_blue = 1'b0;
    end else if (state[ST_TEACH_FAIL]) begin
      next_blue = bl.fast;
    end else if (state[ST_TEACHING] || state[ST_MUTE_RESTART] ||
                 state[ST_OVERRIDE]) begin
      next_blue = bl.flash;
    end else if (state[ST_MUTING]) begin
      next_blue = bl.slow;
    end else if (state[ST_TAUGHT]) begin
      next_blue = 1'b1;
    end else begin
      next_blue = 1'b0;
    end
  end

  // lamp drivers from flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lamp1_red <= 1'b0;
      lamp1_green <= 1'b0;
      lamp2_yellow <= 1'b0;
      lamp3_blue <= 1'b0;
    end else begin
      lamp1_red <= next_red;
      lamp1_green <= next_green;
      lamp2_yellow <= next_yellow;
      lamp3_blue <= next_blue;
    end
  end
endmodule
`default_nettype wire

// ==== inc/lcsi_pkg.sv ====
`default_nettype none
package lcsi_pkg;
  // clock rate and blink timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SLOW_HZ = 1;
  localparam int unsigned FAST_HZ = 10;
  localparam int unsigned FLASH_ON_MS = 100;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int unsigned CNT_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] LAMP_OFS = 8'h0C;

  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // device state fields written by software
  localparam int ST_WEAK = 0;
  localparam int ST_EXT_FAULT = 1;
  localparam int ST_INT_FAULT = 2;
  localparam int ST_RI_ENABLED = 3;
  localparam int ST_RI_RELEASED = 4;
  localparam int ST_FIELD_CLEAR = 5;
  localparam int ST_UP_ENABLE = 6;
  localparam int ST_UP_OPEN = 7;
  localparam int ST_TAUGHT = 8;
  localparam int ST_MUTING = 9;
  localparam int ST_TEACHING = 10;
  localparam int ST_MUTE_RESTART = 11;
  localparam int ST_OVERRIDE = 12;
  localparam int ST_TEACH_FAIL = 13;
  localparam int ST_W = 14;
  localparam logic [ST_W-1:0] STATE_RST = 14'h0000;

  // command fields, write-one pulses
  localparam int CMD_BURST_BIT = 0;
  localparam int CMD_TWO_BIT = 1;

  // lamp readback fields
  localparam int LP_RED = 0;
  localparam int LP_GREEN = 1;
  localparam int LP_YELLOW = 2;
  localparam int LP_BLUE = 3;
  localparam int LP_CH_ONE = 4;
  localparam int LP_CH_TWO = 5;
  localparam int LP_BURST = 6;
  localparam int LP_OUT_ON = 7;

  typedef enum logic [1:0] {
    LCSI_B_IDLE,
    LCSI_B_WAIT,
    LCSI_B_ON,
    LCSI_B_OFF
  } lcsi_burst_t;
endpackage
`default_nettype wire

// ==== inc/lcsi_blink_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lcsi_blink_if;
  logic restart;
  logic slow;
  logic fast;
  logic flash;
  logic slow_tick;
  modport gen (input restart, output slow, fast, flash, slow_tick);
  modport user (output restart, input slow, fast, flash, slow_tick);
endinterface
`default_nettype wire

// ==== design/lcsi_blink_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcsi_blink_gen
  import lcsi_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned FLASH_ON = FLASH_ON_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  lcsi_blink_if.gen bl
);
  logic [1:0] phase;
  logic [1:0] tick;
  logic [CNT_W-1:0] cnt [2];

  // one divider per rate, square wave at half duty
  for (genvar g = 0; g < 2; g++) begin : g_div
    localparam int unsigned HALF = (g == 0) ? SLOW_HALF : FAST_HALF;
    assign tick[g] = (cnt[g] == CNT_W'(HALF - 1));
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cnt[g] <= '0;
        phase[g] <= 1'b0;
      end else if (bl.restart) begin
        cnt[g] <= '0;
        phase[g] <= 1'b0;
      end else if (tick[g]) begin
        cnt[g] <= '0;
        phase[g] <= ~phase[g];
      end else begin
        cnt[g] <= cnt[g] + 1'b1;
      end
    end
  end

  // short flash: lit at the start of each lit slow half period
  assign bl.flash = phase[0] && (cnt[0] < CNT_W'(FLASH_ON));
  assign bl.slow = phase[0];
  assign bl.fast = phase[1];
  assign bl.slow_tick = tick[0];
endmodule
`default_nettype wire

// ==== design/lcsi_pin_in.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcsi_pin_in (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] pins,
  output logic [3:0] pins_sync,
  output logic optical_channel_one,
  output logic optical_channel_two
);
  logic [3:0] meta;

  // two-stage synchroniser for the pin inputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 4'h0;
      pins_sync <= 4'h0;
    end else begin
      meta <= pins;
      pins_sync <= meta;
    end
  end

  // channel from opposite levels; equal levels select neither
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optical_channel_one <= 1'b0;
      optical_channel_two <= 1'b0;
    end else begin
      optical_channel_one <= pins_sync[2] & ~pins_sync[3];
      optical_channel_two <= ~pins_sync[2] & pins_sync[3];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/lcsi_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcsi_top_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic safety_output_one,
  input wire logic channel_select_a,
  input wire logic channel_select_b,
  input wire logic optical_channel_one,
  input wire logic optical_channel_two,
  input wire logic lamp1_red,
  input wire logic lamp1_green,
  input wire logic lamp2_yellow,
  input wire logic lamp3_blue
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // wiring patterns that pick a channel
  sequence sel_one;
    channel_select_a && !channel_select_b;
  endsequence
  sequence sel_two;
    !channel_select_a && channel_select_b;
  endsequence
  // channel decode, lamp exclusivity, green off, dark release, bus answer
  a_ch_one: assert property (sel_one [*4] |=> optical_channel_one)
    else $error("channel one not selected");
  a_ch_two: assert property (sel_two [*4] |=> optical_channel_two)
    else $error("channel two not selected");
  a_ch_excl: assert property (
    !(optical_channel_one && optical_channel_two))
    else $error("both channels selected");
  a_lamp1_excl: assert property (!(lamp1_red && lamp1_green))
    else $error("lamp one red and green together");
  a_green_off: assert property (
    (!safety_output_one) [*4] |=> !lamp1_green)
    else $error("green while outputs off");
  a_dark_release: assert property ($rose(rst_n) |->
    !lamp1_red && !lamp1_green && !lamp2_yellow && !lamp3_blue)
    else $error("lamp lit at reset release");
  a_bus_ready: assert property (hreadyout)
    else $error("wait state inserted");
  a_bus_okay: assert property (!hresp)
    else $error("error response");
endmodule
bind lcsi_top lcsi_top_checker u_chk (.clock(clock), .rst_n(rst_n),
  .hreadyout(hreadyout), .hresp(hresp), .safety_output_one(safety_output_one),
  .channel_select_a(channel_select_a), .channel_select_b(channel_select_b),
  .optical_channel_one(optical_channel_one),
  .optical_channel_two(optical_channel_two), .lamp1_red(lamp1_red),
  .lamp1_green(lamp1_green), .lamp2_yellow(lamp2_yellow),
  .lamp3_blue(lamp3_blue));
`default_nettype wire

// ==== testbench/lcsi_wiring.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcsi_wiring (
  input wire logic sel_two,
  input wire logic outs_on,
  output logic channel_select_a,
  output logic channel_select_b,
  output logic safety_output_one,
  output logic safety_output_two
);
  // channel inputs always wired to opposite levels
  assign channel_select_a = !sel_two;
  assign channel_select_b = sel_two;
  // both safety outputs switch together
  assign safety_output_one = outs_on;
  assign safety_output_two = outs_on;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  import lcsi_pkg::*;
  typedef struct {logic [13:0] st; logic on; logic [31:0] lp; int ix; int hi;}
    lcsi_row_t;
  logic clock, rst_n, hsel, hwrite, sel_two, outs_on, rdy, resp, ch1, ch2;
  logic s1, s2, ca, cb, lp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [3:0] lamps;
  int miscompares, checks_done, n;
  // steady rows check readback, blinking rows the lit run length
  lcsi_row_t rows [15] = '{
    '{14'h0000, 0, 32'h11, 0, 0}, '{14'h0000, 1, 32'h92, 0, 0},
    '{14'h0068, 0, 32'h15, 0, 0}, '{14'h0018, 0, 32'h11, 0, 0},
    '{14'h0048, 0, 32'h11, 0, 0}, '{14'h0100, 0, 32'h19, 0, 0},
    '{14'h0001, 1, 0, 1, 20}, '{14'h0002, 1, 0, 0, 20},
    '{14'h0006, 0, 0, 0, 4}, '{14'h0080, 0, 0, 2, 20},
    '{14'h0200, 0, 0, 3, 20}, '{14'h0400, 0, 0, 3, 6},
    '{14'h0800, 0, 0, 3, 6}, '{14'h1000, 0, 0, 3, 6},
    '{14'h2200, 0, 0, 3, 4}};
  lcsi_wiring u_wire (.sel_two(sel_two), .outs_on(outs_on),
    .channel_select_a(ca), .channel_select_b(cb),
    .safety_output_one(s1), .safety_output_two(s2));
  lcsi_top #(.SLOW_HALF(20), .FAST_HALF(4), .FLASH_ON(6)) dut (.clock(clock),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hreadyout(rdy), .hresp(resp), .hrdata(hrdata),
    .safety_output_one(s1), .safety_output_two(s2), .channel_select_a(ca),
    .channel_select_b(cb), .optical_channel_one(ch1),
    .optical_channel_two(ch2), .lamp1_red(lamps[0]),
    .lamp1_green(lamps[1]), .lamp2_yellow(lamps[2]), .lamp3_blue(lamps[3]));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // bounded wait for hready high at a rising edge
  task automatic wait_ready();
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      if (rdy === 1'b1) return;
    end
    miscompares++;
    tally_and_finish();
  endtask
  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  // length of the next lit run of one lamp
  task automatic hi_run(input int ix, output int cnt);
    logic prev;
    cnt = 0;
    prev = 1'b1;
    for (int k = 0; k < 300 && cnt == 0; k++) begin
      @(posedge clock);
      if (prev === 1'b0 && lamps[ix] === 1'b1) cnt = 1;
      prev = lamps[ix];
    end
    while (cnt > 0 && cnt < 300) begin
      @(posedge clock);
      if (lamps[ix] !== 1'b1) break;
      cnt++;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, sel_two, outs_on} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      outs_on <= rows[i].on;
      bus(1'b1, STATE_OFS, 32'(rows[i].st), rd);
      repeat (8) @(posedge clock);
      if (rows[i].hi == 0) begin
        bus(1'b0, LAMP_OFS, 32'h0, rd);
        `CHK("lamp word", rows[i].lp, rd)
      end else begin
        hi_run(rows[i].ix, n);
        `CHK("lit run", rows[i].hi, n)
      end
      $display("row %0d done", i);
    end
    // changeover bursts of one and two blinks
    for (int b = 1; b <= 2; b++) begin
      bus(1'b1, STATE_OFS, 32'h0, rd);
      bus(1'b1, CMD_OFS, 32'(2 * b - 1), rd);
      n = 0;
      lp = 1'b0;
      repeat (200) begin
        @(posedge clock);
        if (!lp && lamps[2] === 1'b1) n++;
        lp = lamps[2];
      end
      `CHK("burst blinks", b, n)
    end
    $display("burst test done");
    // lamps disabled, channel two, unmapped address
    bus(1'b1, STATE_OFS, 32'h100, rd);
    bus(1'b1, CTRL_OFS, 32'h0, rd);
    sel_two <= 1'b1;
    repeat (8) @(posedge clock);
    bus(1'b0, LAMP_OFS, 32'h0, rd);
    `CHK("dark word", 32'h20, rd)
    `CHK("channels", 2'h2, {ch2, ch1})
    bus(1'b0, 8'h20, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("enable and channel test done");
    // reset in mid run restores the registers
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    `CHK("control", 32'h1, rd)
    bus(1'b0, STATE_OFS, 32'h0, rd);
    `CHK("state", 32'h0, rd)
    $display("reset test done");
    // blink restart: slow phase stays dark for one whole half period
    bus(1'b1, STATE_OFS, 32'h200, rd);
    bus(1'b1, CTRL_OFS, 32'h3, rd);
    repeat (3) @(posedge clock);
    n = 0;
    while (lamps[3] !== 1'b1 && n < 60) begin
      @(posedge clock);
      n++;
    end
    `CHK("restart run", 20, n)
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    `CHK("restart clear", 32'h1, rd)
    $display("restart test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
